/* verilog/smb_regs.svh */
// Constants shared by both ends of the management-bus link.
`ifndef SMB_REGS_SVH
`define SMB_REGS_SVH
`define SMB_DEV_ADDR 7'h2e
`define SMB_RW_WRITE 1'b0
`define SMB_RW_READ 1'b1
`define SMB_CFG1_ADDR 8'h40
`define SMB_BUS_TIMEOUT_DISABLE_BIT 6
`define SMB_CFG1_RST 8'h00
`define SMB_PTR_RST 8'h00
`define SMB_BYTE_RST 8'h00
`define SMB_BIT_LAST 3'h7
`define SMB_ACK_BIT 4'h8
`define SMB_CLK_MHZ 100
`define SMB_TIMEOUT_MS 35
`define SMB_SCL_KHZ 100
`endif

/* verilog/smb_pkg.sv */
// Types shared by both ends of the management-bus link.
package smb_pkg;
    // Slave sequencer states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        SMB_SL_IDLE = 3'h0,
        SMB_SL_ADDR = 3'h1,
        SMB_SL_AACK = 3'h3,
        SMB_SL_WDAT = 3'h2,
        SMB_SL_WACK = 3'h6,
        SMB_SL_RDAT = 3'h7,
        SMB_SL_RACK = 3'h5,
        SMB_SL_IGN = 3'h4
    } smb_sl_state_t;
    // Transaction forms the master can run.
    typedef enum logic [1:0] {
        SMB_CMD_SEND = 2'h0,
        SMB_CMD_WRITE = 2'h1,
        SMB_CMD_RECV = 2'h3,
        SMB_CMD_READ = 2'h2
    } smb_cmd_t;
    // Bus-level steps of a master transaction.
    typedef enum logic [2:0] {
        SMB_OP_START = 3'h0,
        SMB_OP_WADDR = 3'h1,
        SMB_OP_REG = 3'h3,
        SMB_OP_DATA = 3'h2,
        SMB_OP_RADDR = 3'h6,
        SMB_OP_RD = 3'h7,
        SMB_OP_STOP = 3'h5
    } smb_op_t;
    // Master states.
    typedef enum logic {
        SMB_MS_IDLE = 1'b0,
        SMB_MS_RUN = 1'b1
    } smb_ms_state_t;
endpackage

/* verilog/smb_if.sv */
// Two-wire open-drain link joining the bus master and the slave.
`timescale 1ns/100ps
interface smb_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;
    // Wired-AND with a pull-up: a line is low while any enabled driver pulls it low.
    assign scl = !(scl_oe && !scl_o);
    assign sda = !(sda_m_oe && !sda_m_o) && !(sda_s_oe && !sda_s_o);
    modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
    modport slave (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface

/* verilog/smb_slave.sv */
// Slave end: pointer-based byte register access over the two-wire bus.
`timescale 1ns/100ps
`include "smb_regs.svh"
// Function
// RL1: Answer only fixed address 0x2E.
// RL2: Address taken from upper seven bits.
// RL3: Eight bits MSB first, then acknowledge.
// RL4: Data rise with clock high is stop.
// RL5: Master ends write with stop.
// RL6: Master ends read with nack, stop.
// RL7: Direction fixed until next start.
// RL8: Writes of one or two bytes.
// RL9: First write byte loads the pointer.
// RL10: Second write byte stores to register.
// RL11: Read returns register at the pointer.
// RL12: Master sets pointer before unknown read.
// RL13: Data write always follows pointer byte.
// RL14: Send, receive, read and write byte forms.
// RL15: Repeated start decodes fresh address.
// RL16: Master write: address, register, data.
// RL17: Idle 35 ms releases the bus.
// RL18: Config bit six disables timeout.
// RL19: Send byte only updates the pointer.
// RL20: Foreign address ignored until next start.
// RL21: Pointer kept; reads never advance it.
module smb_slave #(
    parameter int TIMEOUT_CYC = `SMB_TIMEOUT_MS * 1000 * `SMB_CLK_MHZ
) (
    input wire logic clk_sys,
    input wire logic rst,
    smb_if.slave bus,
    output logic [7:0] reg_ptr,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr_en,
    output logic [7:0] reg_wr_addr,
    output logic [7:0] reg_wr_data,
    output logic bus_timeout_disable,
    output logic busy
);
    import smb_pkg::*;

    localparam int TW = $clog2(TIMEOUT_CYC + 1);

    smb_sl_state_t state_q;
    logic scl_q, sda_q, scl_p, sda_p;
    logic [7:0] shift_q;
    logic [2:0] cnt_q;
    logic full_q;
    logic [7:0] tx_q;
    logic [1:0] wbyte_q;
    logic mack_q;
    logic sda_oe_q;
    logic [7:0] ptr_q;
    logic [7:0] cfg1_q;
    logic wr_en_q;
    logic [7:0] wr_addr_q, wr_data_q;
    logic [TW-1:0] idle_q;
    logic rise, fall, start_c, stop_c, tmo;
    logic ptr_load, data_store;
    logic [7:0] rd_byte;

    // ****************************************
    // Line sampling and bus conditions
    // ****************************************

    // The lines are synchronous, so one stage plus a previous copy suffices.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_q <= bus.scl;
            sda_q <= bus.sda;
            scl_p <= scl_q;
            sda_p <= sda_q;
        end
    end

    // Edges of the clock and start or stop seen while the clock is high.
    assign rise = scl_q && !scl_p;
    assign fall = !scl_q && scl_p;
    assign start_c = scl_q && scl_p && sda_p && !sda_q; // RL15
    assign stop_c = scl_q && scl_p && !sda_p && sda_q; // RL4

    // ****************************************
    // Bit reception
    // ****************************************

    // Bits are taken on the rising clock edge, MSB first, eight to a byte.
    always_ff @(posedge clk_sys) begin
        if (rst || start_c) begin
            shift_q <= `SMB_BYTE_RST;
            cnt_q <= 3'h0;
            full_q <= 1'b0;
        end else if (fall && full_q) begin
            cnt_q <= 3'h0;
            full_q <= 1'b0;
        end else if (rise && (state_q == SMB_SL_ADDR || state_q == SMB_SL_WDAT || state_q == SMB_SL_RDAT)) begin
            shift_q <= {shift_q[6:0], sda_q}; // RL3
            cnt_q <= cnt_q + 3'h1;
            full_q <= (cnt_q == `SMB_BIT_LAST);
        end
    end

    // ****************************************
    // Transaction sequencer
    // ****************************************

    // A read of the configuration word is served locally so it returns the bits our logic uses.
    assign rd_byte = (ptr_q == `SMB_CFG1_ADDR) ? cfg1_q : reg_rdata; // RL11
    assign ptr_load = (state_q == SMB_SL_WDAT) && fall && full_q && (wbyte_q == 2'h0);
    assign data_store = (state_q == SMB_SL_WDAT) && fall && full_q && (wbyte_q == 2'h1);

    // State moves on falling clock edges, so the data line changes with the clock low; a start, stop or timeout releases it at once.
    always_ff @(posedge clk_sys) begin
        if (rst || stop_c || tmo) begin
            state_q <= SMB_SL_IDLE; // RL17
            sda_oe_q <= 1'b0;
            wbyte_q <= 2'h0;
            tx_q <= `SMB_BYTE_RST;
            mack_q <= 1'b0;
        end else if (start_c) begin
            state_q <= SMB_SL_ADDR; // RL15
            sda_oe_q <= 1'b0;
            wbyte_q <= 2'h0;
        end else begin
            case (state_q)
                SMB_SL_ADDR: begin
                    if (fall && full_q) begin
                        if (shift_q[7:1] == `SMB_DEV_ADDR) begin // RL1 RL2
                            state_q <= SMB_SL_AACK;
                            sda_oe_q <= 1'b1;
                            mack_q <= (shift_q[0] == `SMB_RW_READ); // RL7
                        end else begin
                            state_q <= SMB_SL_IGN; // RL20
                        end
                    end
                end
                SMB_SL_AACK: begin
                    if (fall) begin
                        if (mack_q) begin
                            state_q <= SMB_SL_RDAT; // RL7
                            tx_q <= rd_byte; // RL11
                            sda_oe_q <= !rd_byte[7];
                        end else begin
                            state_q <= SMB_SL_WDAT; // RL14
                            sda_oe_q <= 1'b0;
                        end
                    end
                end
                SMB_SL_WDAT: begin
                    if (fall && full_q) begin
                        if (wbyte_q == 2'h2) begin
                            state_q <= SMB_SL_IGN; // RL8
                        end else begin
                            state_q <= SMB_SL_WACK;
                            sda_oe_q <= 1'b1; // RL3
                            wbyte_q <= wbyte_q + 2'h1;
                        end
                    end
                end
                SMB_SL_WACK: begin
                    if (fall) begin
                        state_q <= SMB_SL_WDAT;
                        sda_oe_q <= 1'b0;
                    end
                end
                SMB_SL_RDAT: begin
                    if (fall && full_q) begin
                        state_q <= SMB_SL_RACK;
                        sda_oe_q <= 1'b0;
                    end else if (fall) begin
                        tx_q <= {tx_q[6:0], 1'b0}; // RL3
                        sda_oe_q <= !tx_q[6];
                    end
                end
                SMB_SL_RACK: begin
                    if (rise) begin
                        mack_q <= !sda_q;
                    end else if (fall) begin
                        if (mack_q) begin
                            state_q <= SMB_SL_RDAT; // RL21
                            tx_q <= rd_byte;
                            sda_oe_q <= !rd_byte[7];
                        end else begin
                            state_q <= SMB_SL_IGN; // RL6
                        end
                    end
                end
                SMB_SL_IGN: begin
                    sda_oe_q <= 1'b0; // RL20
                end
                default: begin
                    state_q <= SMB_SL_IDLE;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Pointer and register writes
    // ****************************************

    // The pointer survives between transactions and reads leave it alone.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ptr_q <= `SMB_PTR_RST;
        end else if (ptr_load) begin
            ptr_q <= shift_q; // RL9 RL19 RL21
        end
    end

    // Only the byte after the pointer byte is ever written to a register.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_en_q <= 1'b0;
            wr_addr_q <= `SMB_PTR_RST;
            wr_data_q <= `SMB_BYTE_RST;
        end else begin
            wr_en_q <= data_store; // RL10 RL13
            if (data_store) begin
                wr_addr_q <= ptr_q;
                wr_data_q <= shift_q;
            end
        end
    end

    // Local copy of the first configuration word.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg1_q <= `SMB_CFG1_RST;
        end else if (data_store && ptr_q == `SMB_CFG1_ADDR) begin
            cfg1_q <= shift_q; // RL18
        end
    end

    // ****************************************
    // Hung-bus timeout
    // ****************************************

    // Any line change restarts the count; a silent idle bus is never timed out.
    always_ff @(posedge clk_sys) begin
        if (rst || state_q == SMB_SL_IDLE || scl_q != scl_p || sda_q != sda_p || tmo) begin
            idle_q <= '0;
        end else begin
            idle_q <= idle_q + TW'(1);
        end
    end
    assign tmo = !cfg1_q[`SMB_BUS_TIMEOUT_DISABLE_BIT] && (idle_q == TW'(TIMEOUT_CYC - 1)); // RL17 RL18

    assign bus.sda_s_o = 1'b0;
    assign bus.sda_s_oe = sda_oe_q;
    assign reg_ptr = ptr_q;
    assign reg_wr_en = wr_en_q;
    assign reg_wr_addr = wr_addr_q;
    assign reg_wr_data = wr_data_q;
    assign bus_timeout_disable = cfg1_q[`SMB_BUS_TIMEOUT_DISABLE_BIT];
    assign busy = (state_q != SMB_SL_IDLE);
endmodule // smb_slave

/* verilog/smb_master.sv */
// Master end: runs send, write, receive and read byte transactions.
`timescale 1ns/100ps
`include "smb_regs.svh"
module smb_master #(
    parameter int QTR_CYC = (`SMB_CLK_MHZ * 1000) / (`SMB_SCL_KHZ * 4)
) (
    input wire logic clk_sys,
    input wire logic rst,
    smb_if.master bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire smb_pkg::smb_cmd_t cmd,
    input wire logic [7:0] cmd_reg,
    input wire logic [7:0] cmd_data,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_nack
);
    import smb_pkg::*;

    localparam int QW = $clog2(QTR_CYC + 1);

    smb_ms_state_t state_q;
    smb_cmd_t cmd_q;
    logic [7:0] reg_q, data_q, rx_q;
    logic [2:0] idx_q;
    logic [3:0] bit_q;
    logic [1:0] ph_q;
    logic [QW-1:0] qcnt_q;
    logic nack_q, abort_q, scl_oe_q, sda_oe_q;
    logic rsp_valid_q;
    logic [7:0] rsp_data_q;
    logic rsp_nack_q;
    logic tick, is_rd;
    smb_op_t op;
    logic [7:0] tx;

    // Step list of each form; the combined read uses a repeated start.
    function automatic smb_op_t op_at(input smb_cmd_t c, input logic [2:0] i);
        smb_op_t o;
        o = SMB_OP_STOP;
        case (c)
            SMB_CMD_SEND: o = (i == 3'h0) ? SMB_OP_START : (i == 3'h1) ? SMB_OP_WADDR :
                              (i == 3'h2) ? SMB_OP_REG : SMB_OP_STOP; // RL16
            SMB_CMD_WRITE: o = (i == 3'h0) ? SMB_OP_START : (i == 3'h1) ? SMB_OP_WADDR :
                               (i == 3'h2) ? SMB_OP_REG : (i == 3'h3) ? SMB_OP_DATA : SMB_OP_STOP; // RL13 RL16
            SMB_CMD_RECV: o = (i == 3'h0) ? SMB_OP_START : (i == 3'h1) ? SMB_OP_RADDR :
                              (i == 3'h2) ? SMB_OP_RD : SMB_OP_STOP;
            SMB_CMD_READ: o = (i == 3'h0 || i == 3'h3) ? SMB_OP_START : (i == 3'h1) ? SMB_OP_WADDR :
                              (i == 3'h2) ? SMB_OP_REG : (i == 3'h4) ? SMB_OP_RADDR :
                              (i == 3'h5) ? SMB_OP_RD : SMB_OP_STOP; // RL12 RL15
            default: o = SMB_OP_STOP;
        endcase
        return o;
    endfunction

    assign op = abort_q ? SMB_OP_STOP : op_at(cmd_q, idx_q);
    assign is_rd = (op == SMB_OP_RD);
    assign tx = (op == SMB_OP_WADDR) ? {`SMB_DEV_ADDR, `SMB_RW_WRITE} : (op == SMB_OP_RADDR) ?
                {`SMB_DEV_ADDR, `SMB_RW_READ} : (op == SMB_OP_REG) ? reg_q : data_q; // RL2
    assign tick = (state_q == SMB_MS_RUN) && (qcnt_q == QW'(QTR_CYC - 1));

    // ****************************************
    // Quarter-bit divider
    // ****************************************

    // Each clock bit is four quarter periods long.
    always_ff @(posedge clk_sys) begin
        if (rst || state_q == SMB_MS_IDLE || tick) begin
            qcnt_q <= '0;
        end else begin
            qcnt_q <= qcnt_q + QW'(1);
        end
    end

    // ****************************************
    // Bus sequencer
    // ****************************************

    // Quarter 0 sets the data line with the clock low, 1 raises it, 2 samples, 3 lowers it.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= SMB_MS_IDLE;
            cmd_q <= SMB_CMD_SEND;
            reg_q <= `SMB_BYTE_RST;
            data_q <= `SMB_BYTE_RST;
            rx_q <= `SMB_BYTE_RST;
            idx_q <= 3'h0;
            bit_q <= 4'h0;
            ph_q <= 2'h0;
            nack_q <= 1'b0;
            abort_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= `SMB_BYTE_RST;
            rsp_nack_q <= 1'b0;
        end else begin
            rsp_valid_q <= 1'b0;
            if (state_q == SMB_MS_IDLE) begin
                scl_oe_q <= 1'b0;
                sda_oe_q <= 1'b0;
                if (cmd_valid) begin
                    state_q <= SMB_MS_RUN;
                    cmd_q <= cmd;
                    reg_q <= cmd_reg;
                    data_q <= cmd_data;
                    idx_q <= 3'h0;
                    bit_q <= 4'h0;
                    ph_q <= 2'h0;
                    nack_q <= 1'b0;
                    abort_q <= 1'b0;
                end
            end else if (tick) begin
                ph_q <= ph_q + 2'h1;
                case (op)
                    SMB_OP_START: begin
                        case (ph_q)
                            2'h0: begin
                                sda_oe_q <= 1'b0;
                                scl_oe_q <= 1'b1;
                            end
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: sda_oe_q <= 1'b1;
                            default: begin
                                scl_oe_q <= 1'b1;
                                idx_q <= idx_q + 3'h1;
                            end
                        endcase
                    end
                    SMB_OP_STOP: begin
                        case (ph_q)
                            2'h0: begin
                                scl_oe_q <= 1'b1;
                                sda_oe_q <= 1'b1;
                            end
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: sda_oe_q <= 1'b0; // RL5 RL6
                            default: begin
                                state_q <= SMB_MS_IDLE;
                                rsp_valid_q <= 1'b1;
                                rsp_data_q <= rx_q;
                                rsp_nack_q <= nack_q;
                            end
                        endcase
                    end
                    default: begin
                        case (ph_q)
                            2'h0: begin
                                scl_oe_q <= 1'b1;
                                sda_oe_q <= !is_rd && (bit_q != `SMB_ACK_BIT) &&
                                            !tx[3'(`SMB_BIT_LAST - bit_q[2:0])]; // RL3 RL6
                            end
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: begin
                                if (bit_q != `SMB_ACK_BIT) begin
                                    if (is_rd) begin
                                        rx_q <= {rx_q[6:0], bus.sda};
                                    end
                                end else if (!is_rd && bus.sda) begin
                                    nack_q <= 1'b1;
                                end
                            end
                            default: begin
                                scl_oe_q <= 1'b1;
                                if (bit_q == `SMB_ACK_BIT) begin
                                    bit_q <= 4'h0;
                                    idx_q <= idx_q + 3'h1;
                                    abort_q <= nack_q;
                                end else begin
                                    bit_q <= bit_q + 4'h1;
                                end
                            end
                        endcase
                    end
                endcase
            end
        end
    end

    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = scl_oe_q;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = sda_oe_q;
    assign cmd_ready = (state_q == SMB_MS_IDLE);
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
    assign rsp_nack = rsp_nack_q;
endmodule // smb_master

/* verification/smb_link_sva.sv */
// Bus-side checks on the two-wire link joining master and slave.
`timescale 1ns/100ps
`include "smb_regs.svh"
module smb_link_sva (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q, sda_q;
    logic [7:0] shift_q;
    logic [5:0] rise_cnt_q;
    logic start_det, stop_det;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ************************************
    // Line history
    // ************************************
    // Edges are found against last cycle's levels, so a start is seen in the same cycle the data line falls.
    assign start_det = scl && scl_q && sda_q && !sda;
    assign stop_det = scl && scl_q && !sda_q && sda;
    always_ff @(posedge clk_sys) begin
        scl_q <= rst ? 1'b1 : scl;
        sda_q <= rst ? 1'b1 : sda;
    end
    // Clock rises since the last start or stop, and the bits they sampled.
    always_ff @(posedge clk_sys) begin
        if (rst || start_det || stop_det) begin
            rise_cnt_q <= 6'h00;
        end else if (scl && !scl_q) begin
            rise_cnt_q <= rise_cnt_q + 6'h01;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (scl && !scl_q) begin
            shift_q <= {shift_q[6:0], sda};
        end
    end
    // ************************************
    // Properties
    // ************************************
    property p_open_drain; (scl_o == 1'b0) && (sda_m_o == 1'b0) && (sda_s_o == 1'b0); endproperty
    a_open_drain: assert property (p_open_drain) else $error("a driver outputs a high level");
    property p_slave_take_low; $rose(sda_s_oe) |-> !scl; endproperty
    a_slave_take_low: assert property (p_slave_take_low) else $error("slave pulls data while clock high");
    property p_slave_free_low; $fell(sda_s_oe) |-> !scl; endproperty
    a_slave_free_low: assert property (p_slave_free_low) else $error("slave frees data while clock high");
    property p_master_sda; $changed(sda_m_oe) && scl |-> (rise_cnt_q % 6'h9) == 6'h1; endproperty
    a_master_sda: assert property (p_master_sda) else $error("master moves data inside a bit");
    property p_start_clk; start_det |-> ##[1:40] !scl; endproperty
    a_start_clk: assert property (p_start_clk) else $error("no clock after start");
    property p_nine; start_det || stop_det |-> (rise_cnt_q % 6'h9) == 6'h1; endproperty
    a_nine: assert property (p_nine) else $error("frame not a whole number of bytes");
    property p_addr; $rose(sda_s_oe) && rise_cnt_q == 6'h8 |-> shift_q[7:1] == `SMB_DEV_ADDR; endproperty
    a_addr: assert property (p_addr) else $error("slave acked a foreign address");
    property p_ack_len; $rose(sda_s_oe) |-> sda_s_oe [*8]; endproperty
    a_ack_len: assert property (p_ack_len) else $error("slave drive too short");
    c_start: cover property (start_det);
    c_stop: cover property (stop_det);
    c_addr_ack: cover property ($rose(sda_s_oe) && rise_cnt_q == 6'h8);
endmodule // smb_link_sva

/* verification/smbus_slave_register_access_tb.sv */
// Self-checking bench for the two-wire register access link.
`timescale 1ns/100ps
`include "smb_regs.svh"
module smbus_slave_register_access_tb;
    import smb_pkg::*;
    logic clk_sys, rst;
    logic cmd_valid, cmd_ready;
    smb_cmd_t cmd;
    logic [7:0] cmd_reg, cmd_data;
    logic rsp_valid, rsp_nack;
    logic [7:0] rsp_data;
    logic [7:0] reg_ptr;
    logic reg_wr_en;
    logic [7:0] reg_wr_addr, reg_wr_data;
    logic bus_timeout_disable, busy;
    logic [7:0] wr_addr_seen, wr_data_seen;
    int wr_cnt = 0, error_cnt = 0, n_checks = 0, cyc = 0;
    smb_if bus ();
    smb_if bus2 ();
    // ************************************
    // Ends under test
    // ************************************
    // Read data is the pointer XOR a5, a known byte for each address.
    smb_master #(.QTR_CYC(8)) smb_master_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .cmd_reg(cmd_reg), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
    smb_slave #(.TIMEOUT_CYC(2000)) smb_slave_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus),
        .reg_ptr(reg_ptr), .reg_rdata(reg_ptr ^ 8'ha5), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .bus_timeout_disable(bus_timeout_disable), .busy(busy));
    // A second slave faces a hand-driven master that can send a foreign address.
    smb_slave #(.TIMEOUT_CYC(2000)) smb_slave_inst_b (.clk_sys(clk_sys), .rst(rst), .bus(bus2),
        .reg_ptr(), .reg_rdata(8'h00), .reg_wr_en(), .reg_wr_addr(), .reg_wr_data(),
        .bus_timeout_disable(), .busy());
    smb_link_sva smb_link_sva_inst (.clk_sys(clk_sys), .rst(rst), .scl_o(bus.scl_o), .scl_oe(bus.scl_oe),
        .sda_m_o(bus.sda_m_o), .sda_m_oe(bus.sda_m_oe), .sda_s_o(bus.sda_s_o), .sda_s_oe(bus.sda_s_oe),
        .scl(bus.scl), .sda(bus.sda));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Register writes are logged so scenarios can count them.
    always @(posedge clk_sys) begin
        cyc++;
        if (reg_wr_en === 1'b1) begin
            wr_cnt++;
            wr_addr_seen = reg_wr_addr;
            wr_data_seen = reg_wr_data;
        end
        if (cyc == 30000) begin
            error_cnt++;
            finish_test();
        end
    end
    // ************************************
    // Shared tasks
    // ************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    // One transaction to our own address, which must be acked and leave both ends idle.
    task automatic run(input smb_cmd_t c, input logic [7:0] r, input logic [7:0] d);
        @(negedge clk_sys);
        cmd = c;
        cmd_reg = r;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(negedge clk_sys);
        chk({7'h00, rsp_nack}, 8'h00);
        chk({6'h00, busy, cmd_ready}, 8'h01);
    endtask
    // Clock moves first and data two cycles later; a data change under a high clock makes a start or stop.
    task automatic line2(input logic c, input logic d);
        @(negedge clk_sys);
        bus2.scl_oe = !c;
        repeat (2) @(negedge clk_sys);
        bus2.sda_m_oe = !d;
        repeat (6) @(negedge clk_sys);
    endtask
    // ************************************
    // Scenarios
    // ************************************
    task automatic t_write;
        wr_cnt = 0;
        run(SMB_CMD_WRITE, 8'h12, 8'h3c);
        chk(reg_ptr, 8'h12);
        chk(wr_addr_seen, 8'h12);
        chk(wr_data_seen, 8'h3c);
        chk(wr_cnt[7:0], 8'h01);
    endtask
    // Send byte moves only the pointer; receives then reread that register unchanged.
    task automatic t_send_recv;
        wr_cnt = 0;
        run(SMB_CMD_SEND, 8'h27, 8'h00);
        chk(reg_ptr, 8'h27);
        chk(wr_cnt[7:0], 8'h00);
        for (int i = 0; i < 2; i++) begin
            run(SMB_CMD_RECV, 8'h99, 8'h00);
            chk(rsp_data, 8'h27 ^ 8'ha5);
            chk(reg_ptr, 8'h27);
        end
    endtask
    task automatic t_read;
        run(SMB_CMD_READ, 8'h55, 8'h00);
        chk(rsp_data, 8'h55 ^ 8'ha5);
        chk(reg_ptr, 8'h55);
    endtask
    task automatic t_cfg;
        run(SMB_CMD_WRITE, `SMB_CFG1_ADDR, 8'h40);
        chk({7'h00, bus_timeout_disable}, 8'h01);
        run(SMB_CMD_RECV, 8'h00, 8'h00);
        chk({7'h00, rsp_data[`SMB_BUS_TIMEOUT_DISABLE_BIT]}, 8'h01);
        run(SMB_CMD_WRITE, `SMB_CFG1_ADDR, 8'hbf);
        chk({7'h00, bus_timeout_disable}, 8'h00);
    endtask
    // The second slave must ack only its own address byte.
    task automatic t_foreign;
        logic [7:0] a;
        for (int k = 0; k < 2; k++) begin
            a = (k == 0) ? 8'h5e : {`SMB_DEV_ADDR, `SMB_RW_WRITE};
            line2(1'b1, 1'b0);
            for (int i = 7; i >= 0; i--) begin
                line2(1'b0, a[i]);
                line2(1'b1, a[i]);
            end
            line2(1'b0, 1'b1);
            line2(1'b1, 1'b1);
            chk({7'h00, bus2.sda_s_oe}, {7'h00, a[7:1] == `SMB_DEV_ADDR});
            repeat (2100) @(negedge clk_sys);
            chk({7'h00, bus2.sda_s_oe}, 8'h00);
            line2(1'b0, 1'b0);
            line2(1'b1, 1'b0);
            line2(1'b1, 1'b1);
        end
    endtask
    task automatic finish_test;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ************************************
    // Main sequence
    // ************************************
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd = SMB_CMD_SEND;
        cmd_reg = 8'h00;
        cmd_data = 8'h00;
        bus2.scl_o = 1'b0;
        bus2.scl_oe = 1'b0;
        bus2.sda_m_o = 1'b0;
        bus2.sda_m_oe = 1'b0;
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        chk(reg_ptr, `SMB_PTR_RST);
        chk({7'h00, bus_timeout_disable}, 8'h00);
        t_write();
        t_send_recv();
        t_read();
        t_cfg();
        t_foreign();
        finish_test();
    end
endmodule // smbus_slave_register_access_tb
